// ---- adc_control_and_interrupt_bench.sv ----
`timescale 1ns/1ps
module adc_control_and_interrupt_bench
	import adcci_pkg::*;
;
	typedef struct packed {
		logic [15:0] i;
		logic [7:0]  d;
		logic [7:0]  e;
		logic [1:0]  r;
	} adcci_row_t;
	typedef struct packed {
		logic [1:0] ch;
		logic [1:0] m;
		logic       en;
		logic [7:0] clk;
		logic       req;
		logic       rt;
	} adcci_conv_t;
	logic              aclk, aresetn, fast_oscillator, slow_oscillator;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0]       s_axi_wdata, s_axi_rdata;
	logic [3:0]        s_axi_wstrb, analog_pin_select;
	logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic              s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic              s_axi_rready, comp_in, conv_busy;
	logic [1:0]        s_axi_bresp, s_axi_rresp, cpu_irq_mask_level;
	logic [39:0]       vin;
	adcci_core_t       core_out;
	adcci_irq_t        irq_out;
	int                fails, checks_done;
	time               t0, dur, base;
	adcci_row_t        rows[7];
	adcci_conv_t       cv[4];
	logic [15:0]       ridx[6];

	adcci_top u_dut (.*);
	adcci_analog_model u_core (.*);

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			fails++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic hang();
		fails++;
		tally_and_finish();
	endtask
	// ready is looked at mid-cycle, so the edge that takes it is known
	task automatic wr(input logic [15:0] i, input logic [7:0] d,
			input logic [1:0] er);
		logic a, w, b;
		int   n;
		s_axi_awaddr <= {i, 2'h0};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		b = 1'b0;
		for (n = 0; n < 50 && !b; n++) begin
			@(negedge aclk);
			a = s_axi_awready;
			w = s_axi_wready;
			b = s_axi_bvalid;
			if (b) chk({30'h0, s_axi_bresp}, {30'h0, er});
			@(posedge aclk);
			if (a) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
		end
		if (!b) hang();
	endtask
	task automatic rd(input logic [15:0] i, input logic [7:0] e,
			input logic [1:0] er);
		logic a, r;
		int   n;
		s_axi_araddr <= {i, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		r = 1'b0;
		for (n = 0; n < 50 && !r; n++) begin
			@(negedge aclk);
			a = s_axi_arready;
			r = s_axi_rvalid;
			if (r) chk(s_axi_rdata, {24'h0, e});
			if (r) chk({30'h0, s_axi_rresp}, {30'h0, er});
			@(posedge aclk);
			if (a) s_axi_arvalid <= 1'b0;
		end
		if (!r) hang();
	endtask
	task automatic wait_idle();
		int n;
		for (n = 0; n < 1000; n++) begin
			@(negedge aclk);
			if (conv_busy === 1'b0) break;
		end
		if (n == 1000) hang();
		@(posedge aclk);
	endtask
	task automatic do_reset();
		int k;
		aresetn <= 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (k = 0; k < 6; k++) begin
			rd(ridx[k], 8'h00, RESP_OKAY);
		end
		chk({28'h0, analog_pin_select}, 32'h0);
		// gate is off after reset, so the converter clock must stand still
		chk({18'h0, core_out}, 32'h0);
	endtask

	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	// both oscillators run from the start, unrelated to aclk
	initial begin
		fast_oscillator = 1'b0;
		#3;
		forever #40 fast_oscillator = ~fast_oscillator;
	end
	initial begin
		slow_oscillator = 1'b0;
		forever #80 slow_oscillator = ~slow_oscillator;
	end

	initial begin
		int k;
		aresetn = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		cpu_irq_mask_level = 2'h0;
		vin = {10'h15A, 10'h2A5, 10'h000, 10'h3FF};
		fails = 0;
		checks_done = 0;
		ridx = '{IDX_PRIO, IDX_IRQEN, IDX_FLAG, IDX_CLKCTL, IDX_PINSEL,
			IDX_START};
		rows = '{'{IDX_PRIO, 8'hC0, 8'hC0, RESP_OKAY},
			'{IDX_IRQEN, 8'h80, 8'h80, RESP_OKAY},
			'{IDX_CLKCTL, 8'h0F, 8'h07, RESP_OKAY},
			'{IDX_PINSEL, 8'h5A, 8'h50, RESP_OKAY},
			'{IDX_START, 8'h03, 8'h03, RESP_OKAY},
			'{IDX_FLAG, 8'h80, 8'h00, RESP_OKAY},
			'{16'hFF30, 8'h55, 8'h00, RESP_SLVERR}};
		cv = '{'{2'h0, 2'h1, 1'b1, 8'h0F, 1'b1, 1'b0},
			'{2'h1, 2'h0, 1'b1, 8'h08, 1'b1, 1'b0},
			'{2'h2, 2'h2, 1'b1, 8'h09, 1'b0, 1'b0},
			'{2'h3, 2'h0, 1'b0, 8'h08, 1'b0, 1'b1}};
		do_reset();
		for (k = 0; k < 7; k++) begin
			wr(rows[k].i, rows[k].d, rows[k].r);
			rd(rows[k].i, rows[k].e, rows[k].r);
		end
		chk({28'h0, analog_pin_select}, 32'h5);
		chk({31'h0, conv_busy}, 32'h0);
		wr(IDX_PRIO, 8'h80, RESP_OKAY);
		wr(IDX_PINSEL, 8'hF0, RESP_OKAY);
		for (k = 0; k < 4; k++) begin
			cpu_irq_mask_level <= cv[k].m;
			wr(IDX_IRQEN, {cv[k].en, 7'h0}, RESP_OKAY);
			wr(IDX_CLKCTL, cv[k].clk, RESP_OKAY);
			wr(IDX_START, {6'h20, cv[k].ch}, RESP_OKAY);
			t0 = $time;
			@(negedge aclk);
			chk({31'h0, conv_busy}, 32'h1);
			chk({30'h0, core_out.channel}, {30'h0, cv[k].ch});
			@(posedge aclk);
			if (cv[k].rt) begin
				repeat (100) @(posedge aclk);
				wr(IDX_START, {6'h20, cv[k].ch}, RESP_OKAY);
			end
			wait_idle();
			dur = $time - t0;
			if (k == 1) base = dur;
			// a restart would add at least the hundred cycles waited
			if (cv[k].rt) chk({31'h0, dur > base + 400}, 32'h0);
			// flag lands one edge after busy falls, the request one more
			repeat (2) @(negedge aclk);
			chk({31'h0, irq_out.req}, {31'h0, cv[k].req});
			if (cv[k].req)
				chk({5'h0, irq_out}, {6'h01, 2'h2, IRQ_VECTOR});
			@(posedge aclk);
			rd(IDX_RESHI, vin[k*10+2 +: 8], RESP_OKAY);
			rd(IDX_RESLO, {6'h0, vin[k*10 +: 2]}, RESP_OKAY);
			rd(IDX_FLAG, 8'h80, RESP_OKAY);
			wr(IDX_FLAG, 8'h00, RESP_OKAY);
			rd(IDX_FLAG, 8'h80, RESP_OKAY);
			wr(IDX_FLAG, 8'h80, RESP_OKAY);
			rd(IDX_FLAG, 8'h00, RESP_OKAY);
			@(negedge aclk);
			chk({31'h0, irq_out.req}, 32'h0);
			@(posedge aclk);
		end
		do_reset();
		tally_and_finish();
	end
endmodule

bind adcci_top adcci_top_props #(
	.DELAY_TICKS  (DELAY_TICKS),
	.SAMPLE_TICKS (SAMPLE_TICKS)
) u_props (.*);

// ---- adcci_analog_model.sv ----
`timescale 1ns/1ps
module adcci_analog_model
	import adcci_pkg::*;
(
	// converter drive and pin routing
	input  wire adcci_core_t  core_out,
	input  wire logic [3:0]   analog_pin_select,
	// held input per channel, as ideal codes
	input  wire logic [39:0]  vin,
	// comparator answer
	output logic              comp_in
);
	logic [RES_W-1:0] level;

	assign level = vin[core_out.channel*RES_W +: RES_W];
	// settles well inside one tick; an unrouted pin answers garbage
	assign #30 comp_in = analog_pin_select[core_out.channel] ?
		(level >= core_out.trial_code) : core_out.trial_code[0];
endmodule

// ---- adcci_pkg.sv ----
package adcci_pkg;

	// register indices; the byte address is four times the index
	localparam logic [15:0] IDX_PRIO   = 16'hFF28;
	localparam logic [15:0] IDX_IRQEN  = 16'hFF2A;
	localparam logic [15:0] IDX_FLAG   = 16'hFF2C;
	localparam logic [15:0] IDX_CLKCTL = 16'hFF80;
	localparam logic [15:0] IDX_PINSEL = 16'hFF81;
	localparam logic [15:0] IDX_START  = 16'hFF82;
	localparam logic [15:0] IDX_RESHI  = 16'hFF83;
	localparam logic [15:0] IDX_RESLO  = 16'hFF84;

	localparam int ADDR_W = 18;
	localparam int RES_W  = 10;

	// field positions inside the byte registers
	localparam int PRIO_LSB    = 6;
	localparam int PRIO_RSV_LSB = 4;
	localparam int IRQEN_BIT   = 7;
	localparam int RSV_BIT     = 6;
	localparam int FLAG_BIT    = 7;
	localparam int GATE_BIT    = 3;
	localparam int DIV_LSB     = 0;
	localparam int PIN_LSB     = 4;
	localparam int TRIG_BIT    = 7;
	localparam int CHAN_LSB    = 0;
	localparam int RESLO_BITS  = 2;

	// reset values
	localparam logic [1:0] PRIO_RST = 2'h0;
	localparam logic [2:0] DIV_RST  = 3'h0;
	localparam logic [3:0] PIN_RST  = 4'h0;
	localparam logic [1:0] CHAN_RST = 2'h0;

	// divider code that picks the slow oscillator undivided
	localparam logic [2:0] DIV_SLOW = 3'h7;
	localparam int         PRESC_W  = 6;

	// fixed exception vector of the completion interrupt
	localparam logic [23:0] IRQ_VECTOR = 24'h000024;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		SEQ_IDLE    = 2'h0,
		SEQ_DELAY   = 2'h1,
		SEQ_SAMPLE  = 2'h3,
		SEQ_CONVERT = 2'h2
	} adcci_seq_t;

	// drive toward the analog sample-and-hold and comparator core
	typedef struct packed {
		logic             conv_clk;
		logic             sample_hold;
		logic [1:0]       channel;
		logic [RES_W-1:0] trial_code;
	} adcci_core_t;

	// interrupt request toward the processor
	typedef struct packed {
		logic        req;
		logic [1:0]  level;
		logic [23:0] vector;
	} adcci_irq_t;

endpackage

// ---- adcci_prescaler.sv ----
`timescale 1ns/1ps
module adcci_prescaler
	import adcci_pkg::*;
(
	// clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// oscillator edges, already synchronised
	input  wire logic       fast_edge,
	input  wire logic       slow_edge,
	// settings
	input  wire logic [2:0] divider,
	input  wire logic       gate,
	// gated conversion clock
	output logic            tick,
	output logic            conv_clk
);

	logic [PRESC_W-1:0] cnt_r;
	logic               tick_nxt;

	function automatic logic [PRESC_W-1:0] div_mask(input logic [2:0] sel);
		div_mask = PRESC_W'((7'h01 << sel) - 7'h01);
	endfunction

	always_comb begin
		if (!gate) begin
			tick_nxt = 1'b0;
		end else if (divider == DIV_SLOW) begin
			tick_nxt = slow_edge;
		end else begin
			tick_nxt = fast_edge &&
				((cnt_r & div_mask(divider)) == div_mask(divider));
		end
	end

	// free-running so the divided phase does not depend on the gate
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= '0;
		end else if (fast_edge) begin
			cnt_r <= cnt_r + PRESC_W'(1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick     <= 1'b0;
			conv_clk <= 1'b0;
		end else begin
			tick <= tick_nxt;
			if (tick_nxt) begin
				conv_clk <= ~conv_clk;
			end
		end
	end

endmodule

// ---- adcci_sar_seq.sv ----
`timescale 1ns/1ps
module adcci_sar_seq
	import adcci_pkg::*;
#(
	parameter logic [3:0] DELAY_TICKS  = 4'h2,
	parameter logic [3:0] SAMPLE_TICKS = 4'h3
)(
	// clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// control
	input  wire logic             start,
	input  wire logic             tick,
	input  wire logic             comp,
	// status and result
	output logic                  busy,
	output logic                  done,
	output logic [RES_W-1:0]      result,
	// toward the analog core
	output logic                  sample_hold,
	output logic [RES_W-1:0]      trial_code
);

	adcci_seq_t       state_r;
	logic [3:0]       cnt_r;
	logic [3:0]       bit_r;
	logic [RES_W-1:0] code_r;
	logic [RES_W-1:0] kept;

	assign busy        = (state_r != SEQ_IDLE);
	assign sample_hold = (state_r == SEQ_SAMPLE);
	assign trial_code  = code_r;
	assign kept = comp ? code_r : (code_r & ~(RES_W'(1) << bit_r));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= SEQ_IDLE;
			cnt_r   <= 4'h0;
			bit_r   <= 4'h0;
			code_r  <= '0;
			done    <= 1'b0;
			result  <= '0;
		end else begin
			done <= 1'b0;
			case (state_r)
				SEQ_IDLE: begin
					cnt_r <= 4'h0;
					if (start) begin
						state_r <= SEQ_DELAY;
					end
				end
				SEQ_DELAY: begin
					if (tick) begin
						cnt_r <= cnt_r + 4'h1;
						if (cnt_r == DELAY_TICKS - 4'h1) begin
							cnt_r   <= 4'h0;
							state_r <= SEQ_SAMPLE;
						end
					end
				end
				SEQ_SAMPLE: begin
					if (tick) begin
						cnt_r <= cnt_r + 4'h1;
						if (cnt_r == SAMPLE_TICKS - 4'h1) begin
							state_r <= SEQ_CONVERT;
							bit_r   <= 4'(RES_W - 1);
							code_r  <= RES_W'(1) << (RES_W - 1);
						end
					end
				end
				SEQ_CONVERT: begin
					if (tick) begin
						// successive approximation, msb first
						if (bit_r == 4'h0) begin
							code_r  <= kept;
							result  <= kept;
							done    <= 1'b1;
							state_r <= SEQ_IDLE;
						end else begin
							code_r <= kept | (RES_W'(1) << (bit_r - 4'h1));
							bit_r  <= bit_r - 4'h1;
						end
					end
				end
				default: begin
					state_r <= SEQ_IDLE;
				end
			endcase
		end
	end

endmodule

// ---- adcci_top.sv ----
// Summary of operation
// - four pin-select bits route shared pins to analog inputs, readable, reset zero
// - divider 111 picks slow oscillator; 110..000 fast divided 64..1
// - gate bit passes conversion clock only when one; reads as zero
// - writing one to trigger starts conversion when none is running; trigger always reads zero
// - channel field selects one of four analog inputs, resets to first
// - result bits 9..2 in high byte, bits 1..0 in low byte
// - result registers have no reset value until first conversion
// - two-bit priority field sets completion interrupt level, zero means none
// - enable bit permits completion interrupt request, resets disabled
// - completion flag sets on every finished conversion regardless of enable
// - request only when flag, enable and priority above cpu mask
// - writing one clears completion flag, zero leaves it
// - delay, sample, approximate, then load result and set flag together
// - completion interrupt uses its own fixed vector address
`timescale 1ns/1ps
module adcci_top
	import adcci_pkg::*;
#(
	parameter logic [3:0] DELAY_TICKS  = 4'h2,
	parameter logic [3:0] SAMPLE_TICKS = 4'h3
)(
	// clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// axi4-lite write address
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// axi4-lite write response
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// axi4-lite read address
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	// axi4-lite read data
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// oscillators and comparator, asynchronous
	input  wire logic              fast_oscillator,
	input  wire logic              slow_oscillator,
	input  wire logic              comp_in,
	// analog side
	output logic [3:0]             analog_pin_select,
	output adcci_core_t            core_out,
	// processor interrupt
	input  wire logic [1:0]        cpu_irq_mask_level,
	output adcci_irq_t             irq_out,
	output logic                   conv_busy
);

	// ---------------------------------------------------------------
	// software-visible state
	logic [1:0]       completion_irq_priority_r;
	logic [1:0]       prio_rsv_r;
	logic             completion_irq_enable_r;
	logic             irqen_rsv_r;
	logic             completion_flag_r;
	logic             flag_rsv_r;
	logic             converter_clock_gate_r;
	logic [2:0]       converter_clock_divider_r;
	logic [3:0]       analog_pin_select_r;
	logic [1:0]       input_channel_select_r;
	logic [RES_W-1:0] conversion_result_r;
	logic             trigger_r;

	// ---------------------------------------------------------------
	// bus slave state
	logic              aw_held_r;
	logic              w_held_r;
	logic [15:0]       wr_idx_r;
	logic [7:0]        wr_byte_r;
	logic              wr_lane_r;
	logic              wr_go;
	logic [15:0]       rd_idx;

	// ---------------------------------------------------------------
	// pin synchronisers and edge detect
	logic [2:0] sync1_r;
	logic [2:0] sync2_r;
	logic [1:0] osc_prev_r;
	logic       fast_edge;
	logic       slow_edge;

	// converter links
	logic             conv_tick;
	logic             conv_clk;
	logic             seq_done;
	logic [RES_W-1:0] seq_result;
	logic             seq_sample;
	logic [RES_W-1:0] seq_code;

	function automatic logic is_mapped(input logic [15:0] idx);
		case (idx)
			IDX_PRIO, IDX_IRQEN, IDX_FLAG, IDX_CLKCTL,
			IDX_PINSEL, IDX_START, IDX_RESHI, IDX_RESLO: begin
				is_mapped = 1'b1;
			end
			default: begin
				is_mapped = 1'b0;
			end
		endcase
	endfunction

	function automatic logic [15:0] word_idx(input logic [ADDR_W-1:0] a);
		word_idx = a[ADDR_W-1:2];
	endfunction

	// ---------------------------------------------------------------
	// the comparator and oscillators come from outside the clock domain
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_r    <= 3'h0;
			sync2_r    <= 3'h0;
			osc_prev_r <= 2'h0;
		end else begin
			sync1_r    <= {comp_in, slow_oscillator, fast_oscillator};
			sync2_r    <= sync1_r;
			osc_prev_r <= sync2_r[1:0];
		end
	end

	assign fast_edge = sync2_r[0] & ~osc_prev_r[0];
	assign slow_edge = sync2_r[1] & ~osc_prev_r[1];

	// ---------------------------------------------------------------
	// write channel: address and data are taken in either order
	assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
	assign wr_go         = aw_held_r && w_held_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			wr_idx_r  <= 16'h0000;
		end else if (wr_go) begin
			aw_held_r <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_r <= 1'b1;
			wr_idx_r  <= word_idx(s_axi_awaddr);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r  <= 1'b0;
			wr_byte_r <= 8'h00;
			wr_lane_r <= 1'b0;
		end else if (wr_go) begin
			w_held_r <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_r  <= 1'b1;
			wr_byte_r <= s_axi_wdata[7:0];
			wr_lane_r <= s_axi_wstrb[0];
		end
	end

	// unmapped addresses answer with a slave error and change nothing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= is_mapped(wr_idx_r) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// register writes; only byte lane 0 carries data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			completion_irq_priority_r <= PRIO_RST;
			prio_rsv_r                <= 2'h0;
			completion_irq_enable_r   <= 1'b0;
			irqen_rsv_r               <= 1'b0;
			flag_rsv_r                <= 1'b0;
		end else if (wr_go && wr_lane_r) begin
			if (wr_idx_r == IDX_PRIO) begin
				completion_irq_priority_r <= wr_byte_r[PRIO_LSB +: 2];
				// kept as storage; software is told never to set them
				prio_rsv_r <= wr_byte_r[PRIO_RSV_LSB +: 2];
			end
			if (wr_idx_r == IDX_IRQEN) begin
				completion_irq_enable_r <= wr_byte_r[IRQEN_BIT];
				irqen_rsv_r             <= wr_byte_r[RSV_BIT];
			end
			if (wr_idx_r == IDX_FLAG) begin
				flag_rsv_r <= wr_byte_r[RSV_BIT];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			converter_clock_gate_r    <= 1'b0;
			converter_clock_divider_r <= DIV_RST;
			analog_pin_select_r       <= PIN_RST;
			input_channel_select_r    <= CHAN_RST;
		end else if (wr_go && wr_lane_r) begin
			if (wr_idx_r == IDX_CLKCTL) begin
				converter_clock_gate_r    <= wr_byte_r[GATE_BIT];
				converter_clock_divider_r <= wr_byte_r[DIV_LSB +: 3];
			end
			if (wr_idx_r == IDX_PINSEL) begin
				analog_pin_select_r <= wr_byte_r[PIN_LSB +: 4];
			end
			if (wr_idx_r == IDX_START) begin
				input_channel_select_r <= wr_byte_r[CHAN_LSB +: 2];
			end
		end
	end

	// trigger is a one-cycle pulse; it lands on the same edge as the channel
	// so the conversion starts with the channel of the same write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			trigger_r <= 1'b0;
		end else begin
			trigger_r <= wr_go && wr_lane_r && (wr_idx_r == IDX_START) &&
				wr_byte_r[TRIG_BIT] && !conv_busy;
		end
	end

	// completion flag: a finishing conversion beats a clearing write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			completion_flag_r <= 1'b0;
		end else if (seq_done) begin
			completion_flag_r <= 1'b1;
		end else if (wr_go && wr_lane_r && (wr_idx_r == IDX_FLAG) &&
				wr_byte_r[FLAG_BIT]) begin
			completion_flag_r <= 1'b0;
		end
	end

	// result has no reset on purpose; it is loaded with the flag
	always_ff @(posedge aclk) begin
		if (seq_done) begin
			conversion_result_r <= seq_result;
		end
	end

	// ---------------------------------------------------------------
	// read channel: answer on the same edge that takes the address
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_idx        = word_idx(s_axi_araddr);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
			s_axi_rdata  <= 32'h00000000;
			case (rd_idx)
				IDX_PRIO: begin
					s_axi_rdata[PRIO_LSB +: 2]     <= completion_irq_priority_r;
					s_axi_rdata[PRIO_RSV_LSB +: 2] <= prio_rsv_r;
				end
				IDX_IRQEN: begin
					s_axi_rdata[IRQEN_BIT] <= completion_irq_enable_r;
					s_axi_rdata[RSV_BIT]   <= irqen_rsv_r;
				end
				IDX_FLAG: begin
					s_axi_rdata[FLAG_BIT] <= completion_flag_r;
					s_axi_rdata[RSV_BIT]  <= flag_rsv_r;
				end
				IDX_CLKCTL: begin
					// gate bit is not readable and shows zero
					s_axi_rdata[DIV_LSB +: 3] <= converter_clock_divider_r;
				end
				IDX_PINSEL: begin
					s_axi_rdata[PIN_LSB +: 4] <= analog_pin_select_r;
				end
				IDX_START: begin
					// trigger bit reads zero
					s_axi_rdata[CHAN_LSB +: 2] <= input_channel_select_r;
				end
				IDX_RESHI: begin
					s_axi_rdata[7:0] <= conversion_result_r[RES_W-1:RESLO_BITS];
				end
				IDX_RESLO: begin
					s_axi_rdata[RESLO_BITS-1:0] <=
						conversion_result_r[RESLO_BITS-1:0];
				end
				default: begin
					s_axi_rdata <= 32'h00000000;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// interrupt request, registered one edge after its causes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_out <= '0;
		end else begin
			irq_out.req <= completion_flag_r && completion_irq_enable_r &&
				(completion_irq_priority_r > cpu_irq_mask_level);
			irq_out.level  <= completion_irq_priority_r;
			irq_out.vector <= IRQ_VECTOR;
		end
	end

	// ---------------------------------------------------------------
	// converter clock and sequencer
	adcci_prescaler u_prescaler (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.fast_edge (fast_edge),
		.slow_edge (slow_edge),
		.divider   (converter_clock_divider_r),
		.gate      (converter_clock_gate_r),
		.tick      (conv_tick),
		.conv_clk  (conv_clk)
	);

	// the comparator bit must settle within one conversion tick
	adcci_sar_seq #(
		.DELAY_TICKS  (DELAY_TICKS),
		.SAMPLE_TICKS (SAMPLE_TICKS)
	) u_sar_seq (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.start       (trigger_r),
		.tick        (conv_tick),
		.comp        (sync2_r[2]),
		.busy        (conv_busy),
		.done        (seq_done),
		.result      (seq_result),
		.sample_hold (seq_sample),
		.trial_code  (seq_code)
	);

	// ---------------------------------------------------------------
	// outputs toward pads and analog core
	assign analog_pin_select    = analog_pin_select_r;
	assign core_out.conv_clk    = conv_clk;
	assign core_out.sample_hold = seq_sample;
	assign core_out.channel     = input_channel_select_r;
	assign core_out.trial_code  = seq_code;

endmodule

// ---- adcci_top_props.sv ----
`timescale 1ns/1ps
module adcci_top_props
	import adcci_pkg::*;
#(
	parameter logic [3:0] DELAY_TICKS  = 4'h2,
	parameter logic [3:0] SAMPLE_TICKS = 4'h3
)(
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// register bus
	input wire logic        s_axi_awready,
	input wire logic        s_axi_bvalid,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rready,
	// converter and interrupt
	input wire logic [3:0]  analog_pin_select,
	input wire adcci_core_t core_out,
	input wire logic [1:0]  cpu_irq_mask_level,
	input wire adcci_irq_t  irq_out,
	input wire logic        conv_busy
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_conv_start;
		$rose(conv_busy);
	endsequence
	// slowest bench clock gives about 300 cycles per conversion
	sequence s_conv_end;
		##[1:1000] $fell(conv_busy);
	endsequence

	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	// a response needs an address held in the cycle before it
	property p_aw_block;
		$rose(s_axi_bvalid) |-> !$past(s_axi_awready);
	endproperty
	a_aw_block: assert property (p_aw_block) else $error("stray response");
	property p_ar_block;
		$rose(s_axi_rvalid) |-> $past(s_axi_arready);
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("stray read data");
	property p_pin_rst;
		disable iff (1'b0) !aresetn |=> analog_pin_select == 4'h0;
	endproperty
	a_pin_rst: assert property (p_pin_rst) else $error("pins not reset");
	property p_vector;
		irq_out.req |-> irq_out.vector == IRQ_VECTOR;
	endproperty
	a_vector: assert property (p_vector) else $error("bad vector");
	property p_level;
		$rose(irq_out.req) |-> irq_out.level > $past(cpu_irq_mask_level);
	endproperty
	a_level: assert property (p_level) else $error("level not above");
	property p_lvl_nz;
		irq_out.req |-> irq_out.level != 2'h0;
	endproperty
	a_lvl_nz: assert property (p_lvl_nz) else $error("level zero req");
	property p_conv;
		s_conv_start |-> s_conv_end;
	endproperty
	a_conv: assert property (p_conv) else $error("conversion hangs");
	// sampling never opens the conversion; the start delay comes first
	property p_hold_busy;
		core_out.sample_hold |-> conv_busy && !$rose(conv_busy);
	endproperty
	a_hold_busy: assert property (p_hold_busy) else $error("stray hold");
endmodule
